// ===== pimap_consts.vh
// Constants for the process image byte mapper
`ifndef PIMAP_CONSTS_VH
`define PIMAP_CONSTS_VH

// Placement used from reset
`define PIMAP_DEF_COMPLETE 1'b0
`define PIMAP_DEF_BIG_ENDIAN 1'b0
`define PIMAP_DEF_WORD_ALIGN 1'b0

// Byte slots per channel for each placement
`define PIMAP_SLOTS_PLAIN 3'h2
`define PIMAP_SLOTS_PACKED 3'h3
`define PIMAP_SLOTS_ALIGNED 3'h4

// Slot positions inside a channel group
`define PIMAP_SLOT_CS 3'h0
`define PIMAP_SLOT_RES 3'h1

// Value given to a reserved byte
`define PIMAP_RES_BYTE 8'h00

// Field positions inside a FIFO entry
`define PIMAP_CH_LSB 24
`define PIMAP_STAT_LSB 16

`endif

// ===== pimap_mapper.v
// Process image byte mapper: sample FIFO and byte placement sequencer
// Notes on behaviour
// - Reset gives default placement; configuring party may write a new one.
// - Complete evaluation adds a control/status byte to two data bytes.
// - Complete evaluation reserves space in input and output image.
// - Status byte goes to input image at the control byte's slot.
// - Data low byte holds bits 7:0, data high byte bits 15:8.
// - Little-endian puts high byte high; big-endian swaps both positions.
// - Aligned complete channel: status low, reserved high, data next word.
// - Reserved slots take image space and carry no meaning.
// - Reserved slots are written with zero by this block.
// - Fieldbus traffic wins over configuration access.
`timescale 1ns/1ps
`default_nettype none
`include "pimap_consts.vh"

module pimap_fifo #(
    parameter W = 25,
    parameter D = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Fill side
    input wire wr_valid,
    output reg wr_ready,
    input wire [W-1:0] wr_data,
    // Drain side
    output reg rd_valid,
    input wire rd_ready,
    output wire [W-1:0] rd_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wp;
    reg [AW-1:0] rp;
    reg [AW:0] count;
    reg [AW:0] next_count;
    wire push;
    wire pop;

    assign push = wr_valid & wr_ready;
    assign pop = rd_ready & rd_valid;
    assign rd_data = mem[rp];

    always @* begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // Storage has no reset; only pointers and flags need a defined value
    always @(posedge sys_clk) begin
        if (push) begin
            mem[wp] <= wr_data;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wp <= {AW{1'b0}};
            rp <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            wr_ready <= 1'b1;
            rd_valid <= 1'b0;
        end else begin
            if (push) begin
                wp <= (wp == D - 1) ? {AW{1'b0}} : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == D - 1) ? {AW{1'b0}} : rp + 1'b1;
            end
            count <= next_count;
            wr_ready <= (next_count != D);
            rd_valid <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule

module pimap_mapper #(
    parameter CW = 1,
    parameter AW = 8,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Channel samples from the terminal
    input wire smp_valid,
    output wire smp_ready,
    input wire [CW-1:0] channel_index,
    input wire [15:0] smp_value,
    input wire [7:0] channel_status_byte,
    // Placement configuration
    input wire cfg_wr_en,
    input wire cfg_complete,
    input wire cfg_big_endian,
    input wire cfg_word_align,
    input wire fb_active,
    // Input image byte writes
    output reg img_wr_en,
    output reg [AW-1:0] img_addr,
    output reg [7:0] img_data,
    output reg img_reserved,
    // Output image control byte read
    output reg out_img_rd_en,
    output reg [AW-1:0] out_img_addr,
    input wire [7:0] out_img_rdata,
    output reg ctrl_valid,
    output reg [CW-1:0] ctrl_channel,
    output reg [7:0] channel_control_byte,
    // Placement in force
    output reg mode_complete,
    output reg mode_big_endian,
    output reg mode_word_align
);
    localparam EW = CW + `PIMAP_CH_LSB, ST_IDLE = 1'b0, ST_SLOT = 1'b1;

    wire [EW-1:0] fifo_out;
    wire fifo_valid;
    wire fifo_pop;
    reg state;
    reg [2:0] slot;
    reg [2:0] nslots;
    reg [CW-1:0] ch;
    reg [15:0] value;
    reg [7:0] status;
    reg cur_complete;
    reg cur_big;
    reg cur_align;
    reg cfg_pend;
    reg pend_complete;
    reg pend_big;
    reg pend_align;
    reg ctrl_wait;
    reg [2:0] next_nslots;
    reg [2:0] data_idx;
    reg [7:0] slot_byte;
    reg slot_res;
    reg slot_cs;
    wire [AW-1:0] base;
    wire [AW-1:0] slot_addr;

    pimap_fifo #(
        .W(EW),
        .D(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_valid(smp_valid),
        .wr_ready(smp_ready),
        .wr_data({channel_index, channel_status_byte, smp_value}),
        .rd_valid(fifo_valid),
        .rd_ready(fifo_pop),
        .rd_data(fifo_out)
    );

    assign fifo_pop = fifo_valid & (state == ST_IDLE);

    // Group size doubles as the channel stride
    always @* begin
        if (!cur_complete) begin
            next_nslots = `PIMAP_SLOTS_PLAIN;
        end else if (cur_align) begin
            next_nslots = `PIMAP_SLOTS_ALIGNED;
        end else begin
            next_nslots = `PIMAP_SLOTS_PACKED;
        end
    end

    assign base = {{(AW-CW){1'b0}}, ch} * {{(AW-3){1'b0}}, nslots};
    assign slot_addr = base + {{(AW-3){1'b0}}, slot};

    // Decode what the current slot carries
    always @* begin
        slot_cs = 1'b0;
        slot_res = 1'b0;
        data_idx = slot;
        if (cur_complete) begin
            if (slot == `PIMAP_SLOT_CS) begin
                slot_cs = 1'b1;
            end else if (cur_align && slot == `PIMAP_SLOT_RES) begin
                slot_res = 1'b1;
            end
            data_idx = cur_align ? slot - 3'h2 : slot - 3'h1;
        end
        if (slot_cs) begin
            slot_byte = status;
        end else if (slot_res) begin
            slot_byte = `PIMAP_RES_BYTE;
        end else if ((data_idx == 3'h0) != cur_big) begin
            slot_byte = value[7:0];
        end else begin
            slot_byte = value[15:8];
        end
    end

    // Configuration waits while the fieldbus is busy and while a
    // channel group is half written, so no group mixes two layouts
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_pend <= 1'b0;
            pend_complete <= `PIMAP_DEF_COMPLETE;
            pend_big <= `PIMAP_DEF_BIG_ENDIAN;
            pend_align <= `PIMAP_DEF_WORD_ALIGN;
            cur_complete <= `PIMAP_DEF_COMPLETE;
            cur_big <= `PIMAP_DEF_BIG_ENDIAN;
            cur_align <= `PIMAP_DEF_WORD_ALIGN;
        end else begin
            if (cfg_wr_en) begin
                cfg_pend <= 1'b1;
                pend_complete <= cfg_complete;
                pend_big <= cfg_big_endian;
                pend_align <= cfg_word_align;
            end else if (cfg_pend && !fb_active && !fifo_pop &&
                         state == ST_IDLE) begin
                cfg_pend <= 1'b0;
                cur_complete <= pend_complete;
                cur_big <= pend_big;
                cur_align <= pend_align;
            end
        end
    end

    // Sequencer: one byte slot per cycle; reserved slots are written as zero
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            slot <= 3'h0;
            nslots <= `PIMAP_SLOTS_PLAIN;
            ch <= {CW{1'b0}};
            value <= 16'h0000;
            status <= 8'h00;
            img_wr_en <= 1'b0;
            img_addr <= {AW{1'b0}};
            img_data <= 8'h00;
            img_reserved <= 1'b0;
            out_img_rd_en <= 1'b0;
            out_img_addr <= {AW{1'b0}};
            ctrl_wait <= 1'b0;
            ctrl_valid <= 1'b0;
            ctrl_channel <= {CW{1'b0}};
            channel_control_byte <= 8'h00;
            mode_complete <= `PIMAP_DEF_COMPLETE;
            mode_big_endian <= `PIMAP_DEF_BIG_ENDIAN;
            mode_word_align <= `PIMAP_DEF_WORD_ALIGN;
        end else begin
            mode_complete <= cur_complete;
            mode_big_endian <= cur_big;
            mode_word_align <= cur_align;
            img_wr_en <= 1'b0;
            img_reserved <= 1'b0;
            out_img_rd_en <= 1'b0;
            ctrl_wait <= out_img_rd_en;
            ctrl_valid <= ctrl_wait;
            if (ctrl_wait) begin
                channel_control_byte <= out_img_rdata;
            end
            case (state)
                ST_IDLE: begin
                    if (fifo_pop) begin
                        ch <= fifo_out[EW-1:`PIMAP_CH_LSB];
                        status <= fifo_out[`PIMAP_CH_LSB-1:`PIMAP_STAT_LSB];
                        value <= fifo_out[`PIMAP_STAT_LSB-1:0];
                        nslots <= next_nslots;
                        slot <= 3'h0;
                        state <= ST_SLOT;
                    end
                end
                ST_SLOT: begin
                    img_wr_en <= 1'b1;
                    img_addr <= slot_addr;
                    img_data <= slot_byte;
                    img_reserved <= slot_res;
                    if (slot_cs) begin
                        out_img_rd_en <= 1'b1;
                        out_img_addr <= slot_addr;
                        ctrl_channel <= ch;
                    end
                    if (slot == nslots - 3'h1) begin
                        state <= ST_IDLE;
                    end else begin
                        slot <= slot + 3'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== pimap_mapper_sva.sv
// Checker of mapper port timing
`timescale 1ns/1ps
`default_nettype none
module pimap_mapper_sva #(
    parameter AW = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Watched ports
    input wire logic fb_active,
    input wire logic img_wr_en,
    input wire logic [AW-1:0] img_addr,
    input wire logic [7:0] img_data,
    input wire logic img_reserved,
    input wire logic out_img_rd_en,
    input wire logic [AW-1:0] out_img_addr,
    input wire logic ctrl_valid,
    input wire logic mode_complete,
    input wire logic mode_big_endian,
    input wire logic mode_word_align
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire [2:0] md = {mode_complete, mode_big_endian, mode_word_align};
    res_zero_a: assert property (img_reserved |-> img_data == 8'h00)
        else $error("reserved byte not zero");
    res_place_a: assert property (img_reserved |-> md[2] && md[0]
        && $past(out_img_rd_en)) else $error("reserved slot misplaced");
    sb_slot_a: assert property (out_img_rd_en |-> img_wr_en && md[2]
        && img_addr == out_img_addr) else $error("status slot off");
    ctrl_due_a: assert property (out_img_rd_en |-> ##[1:2] ctrl_valid)
        else $error("control byte late");
    addr_step_a: assert property (img_wr_en && $past(img_wr_en)
        |-> img_addr == $past(img_addr) + 1'b1) else $error("slot gap");
    plain_len_a: assert property ($rose(img_wr_en) && !md[2]
        |=> img_wr_en ##1 !img_wr_en) else $error("plain group size");
    pack_len_a: assert property ($rose(img_wr_en) && md[2] && !md[0]
        |=> img_wr_en [*2] ##1 !img_wr_en) else $error("packed group size");
    align_len_a: assert property ($rose(img_wr_en) && md[2] && md[0]
        |=> img_wr_en [*3] ##1 !img_wr_en) else $error("aligned group size");
    fb_win_a: assert property (fb_active ##1 fb_active |=> $stable(md))
        else $error("placement changed under fieldbus traffic");
    no_ctl_a: assert property (!md[2] |-> !out_img_rd_en)
        else $error("control read in plain placement");
    c_pack: cover property ($rose(img_wr_en) && md[2] && !md[0]);
    c_res: cover property (img_reserved);
    c_ctl: cover property (ctrl_valid);
endmodule
bind pimap_mapper pimap_mapper_sva #(.AW(AW)) i_pimap_mapper_sva (
    .sys_clk(sys_clk), .rst(rst), .fb_active(fb_active),
    .img_wr_en(img_wr_en), .img_addr(img_addr), .img_data(img_data),
    .img_reserved(img_reserved), .out_img_rd_en(out_img_rd_en),
    .out_img_addr(out_img_addr), .ctrl_valid(ctrl_valid),
    .mode_complete(mode_complete), .mode_big_endian(mode_big_endian),
    .mode_word_align(mode_word_align)
);
`default_nettype wire

// ===== pimap_out_img_model.sv
// Output image memory answering control byte reads
`timescale 1ns/1ps
`default_nettype none
module pimap_out_img_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control byte read
    input wire logic rd_en,
    input wire logic [7:0] addr,
    output logic [7:0] rdata
);
    // Between answers the byte toggles, so stale data cannot pass
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            rdata <= addr ^ 8'ha5;
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule
`default_nettype wire

// ===== pimap_mapper_tb.sv
// Self-checking bench for the byte mapper
`timescale 1ns/1ps
`default_nettype none
module pimap_mapper_tb;
    logic sys_clk = 1'b0, rst = 1'b1, smp_valid = 1'b0, cfg_wr_en = 1'b0;
    logic cfg_complete = 1'b0, cfg_big_endian = 1'b0, cfg_word_align = 1'b0;
    logic fb_active = 1'b0, saw_full = 1'b0;
    logic [0:0] channel_index = 1'b0;
    logic [15:0] smp_value = 16'h0000;
    logic [7:0] channel_status_byte = 8'h00;
    wire smp_ready, img_wr_en, img_reserved, out_img_rd_en, ctrl_valid;
    wire mode_complete, mode_big_endian, mode_word_align;
    wire [7:0] img_addr, img_data, out_img_addr, out_img_rdata;
    wire [7:0] channel_control_byte;
    wire [0:0] ctrl_channel;
    logic [31:0] seed = 32'h0000_bb96, r;
    logic [2:0] md = 3'h0;
    logic [16:0] exp_q[$];
    logic [8:0] ctl_q[$];
    int n_mismatch = 0, cmp_count = 0;
    always #25 sys_clk = ~sys_clk;
    pimap_mapper i_pimap_mapper (.sys_clk(sys_clk), .rst(rst),
        .smp_valid(smp_valid), .smp_ready(smp_ready),
        .channel_index(channel_index), .smp_value(smp_value),
        .channel_status_byte(channel_status_byte), .cfg_wr_en(cfg_wr_en),
        .cfg_complete(cfg_complete), .cfg_big_endian(cfg_big_endian),
        .cfg_word_align(cfg_word_align), .fb_active(fb_active),
        .img_wr_en(img_wr_en), .img_addr(img_addr), .img_data(img_data),
        .img_reserved(img_reserved), .out_img_rd_en(out_img_rd_en),
        .out_img_addr(out_img_addr), .out_img_rdata(out_img_rdata),
        .ctrl_valid(ctrl_valid), .ctrl_channel(ctrl_channel),
        .channel_control_byte(channel_control_byte),
        .mode_complete(mode_complete), .mode_big_endian(mode_big_endian),
        .mode_word_align(mode_word_align));
    pimap_out_img_model i_pimap_out_img_model (.sys_clk(sys_clk),
        .rst(rst), .rd_en(out_img_rd_en), .addr(out_img_addr),
        .rdata(out_img_rdata));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Bytes the placement in force should produce for one sample
    function automatic void plan(logic ch, logic [15:0] v, logic [7:0] s);
        logic [7:0] b;
        b = ch ? (md[2] ? (md[0] ? 8'h04 : 8'h03) : 8'h02) : 8'h00;
        if (md[2]) begin
            exp_q.push_back({1'b0, b, s});
            ctl_q.push_back({ch, b ^ 8'ha5});
            b = b + 8'h01;
        end
        if (md[2] && md[0]) begin
            exp_q.push_back({1'b1, b, 8'h00});
            b = b + 8'h01;
        end
        exp_q.push_back({1'b0, b, md[1] ? v[15:8] : v[7:0]});
        exp_q.push_back({1'b0, b + 8'h01, md[1] ? v[7:0] : v[15:8]});
    endfunction
    task automatic chk(string what, logic [16:0] e, logic [16:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic fail_out();
        n_mismatch++;
        results();
    endtask
    task automatic send(logic ch, logic [15:0] v, logic [7:0] s);
        int n;
        n = 0;
        smp_valid <= 1'b1;
        channel_index <= ch;
        smp_value <= v;
        channel_status_byte <= s;
        plan(ch, v, s);
        do begin
            @(posedge sys_clk);
            n++;
        end while (smp_ready !== 1'b1 && n < 100);
        if (n == 100) fail_out();
    endtask
    task automatic drain();
        int n;
        n = 0;
        while ((exp_q.size() || ctl_q.size()) && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 400) fail_out();
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic setcfg(logic [2:0] c);
        fb_active <= 1'b1;
        cfg_wr_en <= 1'b1;
        {cfg_complete, cfg_big_endian, cfg_word_align} <= c;
        @(posedge sys_clk);
        cfg_wr_en <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("mode held", md, {mode_complete, mode_big_endian, mode_word_align});
        fb_active <= 1'b0;
        repeat (4) @(posedge sys_clk);
        md = c;
        chk("mode", md, {mode_complete, mode_big_endian, mode_word_align});
    endtask
    // Any write beyond the planned bytes finds an empty queue
    always @(posedge sys_clk) begin
        if (img_wr_en === 1'b1) begin
            chk("image byte", exp_q.size() ? exp_q.pop_front() : 17'h1_ffff, {img_reserved, img_addr, img_data});
        end
        if (ctrl_valid === 1'b1) begin
            chk("control byte", ctl_q.size() ? ctl_q.pop_front() : 9'h1ff, {ctrl_channel, channel_control_byte});
        end
        if (smp_ready === 1'b0 && rst === 1'b0) saw_full <= 1'b1;
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk("ready", 17'h0_0001, smp_ready);
        chk("mode", 17'h0_0000, {mode_complete, mode_big_endian, mode_word_align});
        for (int k = 1; k < 9; k++) begin
            setcfg(k[2:0]);
            send(1'b1, 16'hff00, 8'h00);
            send(1'b0, 16'h00ff, 8'hff);
            for (int i = 0; i < 6; i++) begin
                r = rnd();
                send(r[16], r[15:0], r[31:24]);
            end
            smp_valid <= 1'b0;
            drain();
        end
        setcfg(3'h5);
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            send(r[20], r[15:0], r[31:24]);
        end
        smp_valid <= 1'b0;
        drain();
        chk("refused when full", 17'h0_0001, saw_full);
        results();
    end
endmodule
`default_nettype wire
